// *** hw/ioexp_cfg_defines.vh ***
// Register offsets, field positions and reset values of the compare/config bank
`ifndef IOEXP_CFG_DEFINES_VH
`define IOEXP_CFG_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_PIN_CHANGE_IRQ_ENABLE  8'h02
`define ADDR_DEFAULT_COMPARE_VALUE  8'h03
`define ADDR_COMPARE_SOURCE_SELECT  8'h04
`define ADDR_DEVICE_CONFIGURATION   8'h05

// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define CFG_IRQ_ACTIVE_HIGH_BIT     1
`define CFG_IRQ_OPEN_DRAIN_BIT      2
`define CFG_HW_ADDR_ENABLE_BIT      3
`define CFG_SDA_SLEW_DISABLE_BIT    4
`define CFG_PTR_INC_DISABLE_BIT     5
`define CFG_WRITABLE_MASK           8'h3E

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_PIN_CHANGE_IRQ_ENABLE   8'h00
`define RST_DEFAULT_COMPARE_VALUE   8'h00
`define RST_COMPARE_SOURCE_SELECT   8'h00
`define RST_DEVICE_CONFIGURATION    8'h00

`endif

// *** hw/pin_sync.v ***
// Three-stage synchroniser for the port pins, change accepted when last two agree
`timescale 1ns/1ps
module pin_sync (
    input  wire       clk_in,
    input  wire       rst_n_in,
    input  wire       ce_in,
    input  wire [7:0] pin_in,
    output reg  [7:0] pin_out
);
    reg [7:0] s1_q;
    reg [7:0] s2_q;
    reg [7:0] s3_q;

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_q    <= 8'h00;
            s2_q    <= 8'h00;
            s3_q    <= 8'h00;
            pin_out <= 8'h00;
        end else if (ce_in) begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Agreement of stages two and three filters a metastable settle
            pin_out <= (s2_q & s3_q) | (pin_out & (s2_q ^ s3_q));
        end
    end
endmodule

// *** hw/irq_pin_drive.v ***
// Interrupt output pin stage: push-pull with polarity or open-drain
`timescale 1ns/1ps
module irq_pin_drive (
    input  wire irq_active_in,
    input  wire open_drain_in,
    input  wire active_high_in,
    output wire pin_out,
    output wire pin_oe_out
);
    // Open-drain pulls low only and ignores polarity
    assign pin_out    = open_drain_in ? 1'b0 :
                        (active_high_in ? irq_active_in : ~irq_active_in);
    assign pin_oe_out = open_drain_in ? irq_active_in : 1'b1;
endmodule

// *** hw/ioexp_irq_compare_config.v ***
// Compare/config register bank with per-pin change detect for an 8-bit I/O expander
`timescale 1ns/1ps
`include "ioexp_cfg_defines.vh"

// Function
// - Enabled pin in default mode interrupts when level opposes its default bit.
// - Eight-bit default-compare register gives reference level per pin.
// - Select bit set: pin compared with its default-compare bit.
// - Select bit clear: pin compared with previous value; difference interrupts.
// - Compare-source select holds eight independent per-pin bits.
// - Pointer-increment-disable 1 holds address pointer; 0 lets it increment.
// - Slew-disable bit drives SDA slew control: 0 controlled, 1 off.
// - SPI variant: address-enable bit 1 uses address pins, 0 ignores them.
// - I2C variant ignores address-enable bit and always uses address pins.
// - Open-drain bit 1 makes interrupt open-drain, polarity ignored.
// - Push-pull interrupt: polarity 1 active-high, 0 active-low.
// - Configuration bits 7, 6 and 0 always read zero.
// - Only pins enabled in change-enable register can interrupt.
// - Previous-mode reference takes new pin level after an interrupt.
module ioexp_irq_compare_config #(
    parameter SPI_VARIANT = 1'b0
) (
    // Clock, reset, enable
    input  wire       MCLK_IN,
    input  wire       RSTN_IN,
    input  wire       CE_IN,
    // Register port from the serial engine
    input  wire [7:0] REG_ADDR_IN,
    input  wire [7:0] REG_WDATA_IN,
    input  wire       REG_WR_IN,
    input  wire       REG_RD_IN,
    output reg  [7:0] REG_RDATA_OUT,
    output wire       REG_HIT_OUT,
    // Address pointer control
    input  wire       BYTE_DONE_IN,
    output wire       PTR_INCREMENT_OUT,
    // Address matching
    input  wire       HW_ADDRESS_PIN_1_IN,
    input  wire       HW_ADDRESS_PIN_0_IN,
    output wire       ADDR_PINS_USED_OUT,
    output wire [1:0] ADDR_MATCH_BITS_OUT,
    // SDA output control
    output wire       SDA_SLEW_CTRL_EN_OUT,
    // Port pins and interrupt detector
    input  wire [7:0] PORT_PIN_IN,
    input  wire [7:0] PIN_IS_INPUT_IN,
    input  wire       IRQ_CLEAR_IN,
    output reg  [7:0] CHANGE_MATCH_OUT,
    output wire       IRQ_ACTIVE_OUT,
    // Interrupt pin
    output wire       IRQ_PIN_OUT,
    output wire       IRQ_PIN_OE_OUT
);

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    reg  [7:0] pin_change_irq_enable_q;
    reg  [7:0] default_compare_value_q;
    reg  [7:0] compare_source_select_q;
    reg  [7:0] device_configuration_q;
    reg  [7:0] ref_level_q;
    reg        irq_pending_q;
    reg  [7:0] change_match_d;
    wire [7:0] pin_level;

    function is_addr;
        input [7:0] a;
        input [7:0] b;
        begin
            is_addr = (a == b);
        end
    endfunction

    wire wr_en   = CE_IN & REG_WR_IN;
    wire wr_gpen = wr_en & is_addr(REG_ADDR_IN, `ADDR_PIN_CHANGE_IRQ_ENABLE);
    wire wr_def  = wr_en & is_addr(REG_ADDR_IN, `ADDR_DEFAULT_COMPARE_VALUE);
    wire wr_src  = wr_en & is_addr(REG_ADDR_IN, `ADDR_COMPARE_SOURCE_SELECT);
    wire wr_cfg  = wr_en & is_addr(REG_ADDR_IN, `ADDR_DEVICE_CONFIGURATION);

    assign REG_HIT_OUT = is_addr(REG_ADDR_IN, `ADDR_PIN_CHANGE_IRQ_ENABLE)
                       | is_addr(REG_ADDR_IN, `ADDR_DEFAULT_COMPARE_VALUE)
                       | is_addr(REG_ADDR_IN, `ADDR_COMPARE_SOURCE_SELECT)
                       | is_addr(REG_ADDR_IN, `ADDR_DEVICE_CONFIGURATION);

    always @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            pin_change_irq_enable_q <= `RST_PIN_CHANGE_IRQ_ENABLE;
            default_compare_value_q <= `RST_DEFAULT_COMPARE_VALUE;
            compare_source_select_q <= `RST_COMPARE_SOURCE_SELECT;
            device_configuration_q  <= `RST_DEVICE_CONFIGURATION;
        end else begin
            if (wr_gpen) begin
                pin_change_irq_enable_q <= REG_WDATA_IN;
            end
            if (wr_def) begin
                default_compare_value_q <= REG_WDATA_IN;
            end
            if (wr_src) begin
                compare_source_select_q <= REG_WDATA_IN;
            end
            if (wr_cfg) begin
                device_configuration_q <= REG_WDATA_IN & `CFG_WRITABLE_MASK;
            end
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            REG_RDATA_OUT <= 8'h00;
        end else if (CE_IN && REG_RD_IN) begin
            case (REG_ADDR_IN)
                `ADDR_PIN_CHANGE_IRQ_ENABLE: REG_RDATA_OUT <= pin_change_irq_enable_q;
                `ADDR_DEFAULT_COMPARE_VALUE: REG_RDATA_OUT <= default_compare_value_q;
                `ADDR_COMPARE_SOURCE_SELECT: REG_RDATA_OUT <= compare_source_select_q;
                `ADDR_DEVICE_CONFIGURATION:
                    REG_RDATA_OUT <= device_configuration_q & `CFG_WRITABLE_MASK;
                default: REG_RDATA_OUT <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // Configuration outputs
    // ----------------------------------------
    assign PTR_INCREMENT_OUT = BYTE_DONE_IN
                             & ~device_configuration_q[`CFG_PTR_INC_DISABLE_BIT];
    assign SDA_SLEW_CTRL_EN_OUT = ~device_configuration_q[`CFG_SDA_SLEW_DISABLE_BIT];
    // I2C variant always matches on its pins
    assign ADDR_PINS_USED_OUT = SPI_VARIANT ?
                                device_configuration_q[`CFG_HW_ADDR_ENABLE_BIT] : 1'b1;
    // Address pins are static straps; sampled unsynchronised by the matcher
    assign ADDR_MATCH_BITS_OUT = ADDR_PINS_USED_OUT ?
                                 {HW_ADDRESS_PIN_1_IN, HW_ADDRESS_PIN_0_IN} : 2'b00;

    // ----------------------------------------
    // Change detection
    // ----------------------------------------
    pin_sync u_pin_sync (
        .clk_in   (MCLK_IN),
        .rst_n_in (RSTN_IN),
        .ce_in    (CE_IN),
        .pin_in   (PORT_PIN_IN),
        .pin_out  (pin_level)
    );

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_cmp
            always @* begin
                if (compare_source_select_q[g]) begin
                    change_match_d[g] = pin_level[g] ^ default_compare_value_q[g];
                end else begin
                    change_match_d[g] = pin_level[g] ^ ref_level_q[g];
                end
            end
        end
    endgenerate

    wire [7:0] hit = change_match_d & pin_change_irq_enable_q & PIN_IS_INPUT_IN;

    always @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ref_level_q      <= 8'h00;
            irq_pending_q    <= 1'b0;
            CHANGE_MATCH_OUT <= 8'h00;
        end else if (CE_IN) begin
            CHANGE_MATCH_OUT <= hit;
            // New event wins over a clear in the same cycle
            if (|hit) begin
                irq_pending_q <= 1'b1;
            end else if (IRQ_CLEAR_IN) begin
                irq_pending_q <= 1'b0;
            end
            // Reference follows the pin once its change has been flagged
            ref_level_q <= (ref_level_q & ~hit) | (pin_level & hit)
                         | (pin_level & ~pin_change_irq_enable_q);
        end
    end

    assign IRQ_ACTIVE_OUT = irq_pending_q;

    irq_pin_drive u_irq_pin_drive (
        .irq_active_in  (irq_pending_q),
        .open_drain_in  (device_configuration_q[`CFG_IRQ_OPEN_DRAIN_BIT]),
        .active_high_in (device_configuration_q[`CFG_IRQ_ACTIVE_HIGH_BIT]),
        .pin_out        (IRQ_PIN_OUT),
        .pin_oe_out     (IRQ_PIN_OE_OUT)
    );

endmodule

// *** tb/cfg_bank_properties.sv ***
// Port-level assertions for the compare/config bank
`timescale 1ns/1ps
module cfg_bank_props #(
    parameter SPI_VARIANT = 1'b0
) (
    input wire       MCLK_IN,
    input wire       RSTN_IN,
    input wire       CE_IN,
    input wire [7:0] REG_ADDR_IN,
    input wire [7:0] REG_WDATA_IN,
    input wire       REG_WR_IN,
    input wire       REG_RD_IN,
    input wire [7:0] REG_RDATA_OUT,
    input wire       BYTE_DONE_IN,
    input wire       PTR_INCREMENT_OUT,
    input wire       ADDR_PINS_USED_OUT,
    input wire       SDA_SLEW_CTRL_EN_OUT,
    input wire       IRQ_CLEAR_IN,
    input wire [7:0] CHANGE_MATCH_OUT,
    input wire       IRQ_ACTIVE_OUT,
    input wire       IRQ_PIN_OUT,
    input wire       IRQ_PIN_OE_OUT
);
    // Shadow copies rebuilt from bus writes, so outputs are tied to their cause
    reg  [7:0] cfg_q;
    reg  [7:0] ena_q;
    wire       wr = CE_IN && REG_WR_IN;
    always @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            cfg_q <= 8'h00;
            ena_q <= 8'h00;
        end else begin
            if (wr && REG_ADDR_IN == 8'h05) cfg_q <= REG_WDATA_IN & 8'h3E;
            if (wr && REG_ADDR_IN == 8'h02) ena_q <= REG_WDATA_IN;
        end
    end
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!RSTN_IN);
    ptr_step_a: assert property (PTR_INCREMENT_OUT == (BYTE_DONE_IN && !cfg_q[5]))
        else $error("pointer increment wrong");
    slew_ctrl_a: assert property (SDA_SLEW_CTRL_EN_OUT == !cfg_q[4])
        else $error("slew control wrong");
    addr_pins_a: assert property (ADDR_PINS_USED_OUT == (SPI_VARIANT ? cfg_q[3] : 1'b1))
        else $error("address pin use wrong");
    irq_od_a: assert property (cfg_q[2] |->
        !IRQ_PIN_OUT && IRQ_PIN_OE_OUT == IRQ_ACTIVE_OUT)
        else $error("open-drain drive wrong");
    irq_pol_a: assert property (!cfg_q[2] |->
        IRQ_PIN_OE_OUT && IRQ_PIN_OUT == !(cfg_q[1] ^ IRQ_ACTIVE_OUT))
        else $error("push-pull level wrong");
    cfg_read_a: assert property (CE_IN && REG_RD_IN && !REG_WR_IN &&
        REG_ADDR_IN == 8'h05 |=> REG_RDATA_OUT == cfg_q)
        else $error("config readback wrong");
    irq_sticky_a: assert property (IRQ_ACTIVE_OUT && CE_IN && !IRQ_CLEAR_IN |=> IRQ_ACTIVE_OUT)
        else $error("pending dropped");
    enable_mask_a: assert property ((CHANGE_MATCH_OUT & ~$past(ena_q)) == 8'h00)
        else $error("disabled pin hit");
endmodule
bind ioexp_irq_compare_config cfg_bank_props #(.SPI_VARIANT(SPI_VARIANT)) props_i (.*);

// *** tb/host_model.sv ***
// Host model issuing single-byte register accesses
`timescale 1ns/1ps
module host_model (
    input  wire       MCLK_IN,
    input  wire [7:0] REG_RDATA_OUT,
    output reg  [7:0] REG_ADDR_IN,
    output reg  [7:0] REG_WDATA_IN,
    output reg        REG_WR_IN,
    output reg        REG_RD_IN
);
    initial begin
        REG_ADDR_IN = 8'h00;
        REG_WDATA_IN = 8'h00;
        REG_WR_IN = 1'b0;
        REG_RD_IN = 1'b0;
    end
    // Idle lines show the inverse so stale values are never mistaken for live
    task wr(input [7:0] a, input [7:0] v);
        begin
            @(posedge MCLK_IN);
            REG_ADDR_IN <= a;
            REG_WDATA_IN <= v;
            REG_WR_IN <= 1'b1;
            @(posedge MCLK_IN);
            REG_WR_IN <= 1'b0;
            REG_ADDR_IN <= ~a;
            REG_WDATA_IN <= ~v;
        end
    endtask
    task rd(input [7:0] a, output [7:0] v);
        begin
            @(posedge MCLK_IN);
            REG_ADDR_IN <= a;
            REG_RD_IN <= 1'b1;
            @(posedge MCLK_IN);
            REG_RD_IN <= 1'b0;
            REG_ADDR_IN <= ~a;
            @(negedge MCLK_IN);
            v = REG_RDATA_OUT;
        end
    endtask
endmodule

// *** tb/tb_ioexp_irq_compare_config.sv ***
// Self-checking bench for the compare/config bank
`timescale 1ns/1ps
module tb_ioexp_irq_compare_config;
    reg        MCLK_IN = 1'b0;
    reg        RSTN_IN = 1'b0;
    reg        BYTE_DONE_IN = 1'b0;
    reg        IRQ_CLEAR_IN = 1'b0;
    reg  [7:0] PORT_PIN_IN = 8'h00;
    wire       CE_IN = 1'b1;
    wire       HW_ADDRESS_PIN_1_IN = 1'b1;
    wire       HW_ADDRESS_PIN_0_IN = 1'b0;
    wire [7:0] PIN_IS_INPUT_IN = 8'hFF;
    wire [7:0] REG_ADDR_IN, REG_WDATA_IN, REG_RDATA_OUT, CHANGE_MATCH_OUT;
    wire       REG_WR_IN, REG_RD_IN, REG_HIT_OUT, PTR_INCREMENT_OUT, ADDR_PINS_USED_OUT;
    wire [1:0] ADDR_MATCH_BITS_OUT;
    wire       SDA_SLEW_CTRL_EN_OUT, IRQ_ACTIVE_OUT, IRQ_PIN_OUT, IRQ_PIN_OE_OUT;
    reg  [7:0] d;
    integer    n_fail = 0;
    integer    tests_run = 0;
    integer    i;
    always #25 MCLK_IN = ~MCLK_IN;
    host_model HOST (.*);
    ioexp_irq_compare_config DUT (.*);
    task chk(input [7:0] got, input [7:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("ERROR %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task rdc(input [7:0] a, input [7:0] e);
        begin
            HOST.rd(a, d);
            chk(d, e);
        end
    endtask
    task clr;
        begin
            @(posedge MCLK_IN);
            IRQ_CLEAR_IN <= 1'b1;
            @(posedge MCLK_IN);
            IRQ_CLEAR_IN <= 1'b0;
            @(negedge MCLK_IN);
        end
    endtask
    // Eight cycles covers the three-flop sync plus the detect register
    task pin(input [7:0] v);
        begin
            @(posedge MCLK_IN);
            PORT_PIN_IN <= v;
            repeat (8) @(negedge MCLK_IN);
        end
    endtask
    task end_of_test;
        begin
            $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
            if (n_fail == 0 && tests_run > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    initial begin
        #200000;
        n_fail = n_fail + 1;
        end_of_test;
    end
    initial begin
        repeat (5) @(posedge MCLK_IN);
        RSTN_IN <= 1'b1;
        @(negedge MCLK_IN);
        chk(IRQ_PIN_OUT, 1);
        chk(SDA_SLEW_CTRL_EN_OUT, 1);
        chk(ADDR_MATCH_BITS_OUT, 2'b10);
        for (i = 3; i < 6; i = i + 1) rdc(i[7:0], 8'h00);
        for (i = 3; i < 6; i = i + 1) HOST.wr(i[7:0], 8'hFF);
        for (i = 3; i < 6; i = i + 1) rdc(i[7:0], (i == 5) ? 8'h3E : 8'hFF);
        rdc(8'h07, 8'h00);
        chk(REG_HIT_OUT, 0);
        HOST.wr(8'h05, 8'h30);
        BYTE_DONE_IN <= 1'b1;
        @(negedge MCLK_IN);
        chk({PTR_INCREMENT_OUT, SDA_SLEW_CTRL_EN_OUT}, 2'b00);
        HOST.wr(8'h05, 8'h00);
        @(negedge MCLK_IN);
        chk(PTR_INCREMENT_OUT, 1);
        @(posedge MCLK_IN);
        BYTE_DONE_IN <= 1'b0;
        HOST.wr(8'h02, 8'h01);
        HOST.wr(8'h04, 8'h01);
        HOST.wr(8'h03, 8'h00);
        pin(8'h01);
        chk(IRQ_ACTIVE_OUT, 1);
        chk(CHANGE_MATCH_OUT, 8'h01);
        clr;
        chk(IRQ_ACTIVE_OUT, 1);
        HOST.wr(8'h03, 8'h01);
        clr;
        chk(IRQ_ACTIVE_OUT, 0);
        HOST.wr(8'h04, 8'h00);
        pin(8'h00);
        chk(IRQ_ACTIVE_OUT, 1);
        clr;
        repeat (4) @(negedge MCLK_IN);
        chk(IRQ_ACTIVE_OUT, 0);
        pin(8'h02);
        chk(IRQ_ACTIVE_OUT, 0);
        pin(8'h03);
        chk(IRQ_ACTIVE_OUT, 1);
        HOST.wr(8'h05, 8'h02);
        @(negedge MCLK_IN);
        chk({IRQ_PIN_OE_OUT, IRQ_PIN_OUT}, 2'b11);
        HOST.wr(8'h05, 8'h06);
        @(negedge MCLK_IN);
        chk({IRQ_PIN_OE_OUT, IRQ_PIN_OUT}, 2'b10);
        HOST.wr(8'h05, 8'h00);
        @(negedge MCLK_IN);
        chk({IRQ_PIN_OE_OUT, IRQ_PIN_OUT}, 2'b10);
        clr;
        chk({IRQ_PIN_OE_OUT, IRQ_PIN_OUT}, 2'b11);
        end_of_test;
    end
endmodule
